// ### hw/apso_regs.sv
`timescale 1ns/1ps
module apso_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control port
    input wire apso_pkg::apso_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire apso_pkg::apso_word_t reg_wdata,
    output apso_pkg::apso_word_t reg_rdata_q,
    // coefficient set A and settings held elsewhere
    input wire logic [3:0] set_a_integer_coef,
    input wire logic [23:0] set_a_fraction_coef,
    input wire logic set_a_ref_halve,
    input wire logic general_output_disable,
    input wire logic [1:0] word_length_setting,
    input wire logic [1:0] audio_format_field,
    // pll controls
    output logic [3:0] pll_int_coef_q,
    output logic [23:0] pll_frac_coef_q,
    output logic pll_ref_halve_q,
    output logic pll_ref_tick_q,
    // channel mixer
    input wire logic sample_valid,
    input wire logic [23:0] left_in,
    input wire logic [23:0] right_in,
    output logic [23:0] left_out_q,
    output logic [23:0] right_out_q,
    // analog trims and pin three
    output logic [3:0] bias_mode_q,
    output logic [1:0] core_supply_trim_q,
    input wire logic pin3_pad_in,
    output logic pin3_input_enable_q,
    output logic pin3_in_q,
    // serial audio timing
    input wire logic frame_start,
    input wire logic bit_lead,
    input wire logic bit_mid,
    output logic slot_mode_active_q,
    output logic dsp_ab_only_q,
    output logic [5:0] word_bits_q,
    // serial data pin
    output logic serial_audio_out_pin_o,
    output logic serial_audio_out_pin_oe_n,
    output logic output_pull_enable_q,
    output logic output_pull_select_q
);
    import apso_pkg::*;

    apso_word_t regs_q [APSO_NREG];
    logic [APSO_NREG-1:0] hit;
    apso_word_t rd_d;
    logic [1:0] sdo_v;
    logic [1:0] act_v;
    logic [1:0] late_v;
    logic [9:0] start_v [2];
    logic [31:0] word_v [2];
    logic set_b;
    logic [5:0] nb_d;
    logic drive_d;

    // register bank with per-register write masks
    generate
        for (genvar i = 0; i < APSO_NREG; i++) begin : g_reg
            assign hit[i] = (reg_addr == APSO_ADDR[i]);
            always_ff @(posedge clk) begin
                if (reset) begin
                    regs_q[i] <= APSO_RST[i];
                end else if (reg_wr && hit[i]) begin
                    regs_q[i] <= reg_wdata & APSO_MASK[i];
                end
            end
        end
    endgenerate

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_d = 9'h000;
        for (int j = 0; j < APSO_NREG; j++) begin
            if (hit[j]) begin
                rd_d = regs_q[j];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata_q <= 9'h000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end
    end

    assign set_b = regs_q[APSO_I_PLLB][APSO_B_SETSEL];

    always_ff @(posedge clk) begin
        if (reset) begin
            pll_int_coef_q <= 4'h0;
            pll_frac_coef_q <= 24'h000000;
            pll_ref_halve_q <= 1'b0;
        end else if (set_b) begin
            pll_int_coef_q <= regs_q[APSO_I_PLLB][3:0];
            pll_frac_coef_q <= {regs_q[APSO_I_KUP][5:0],
                regs_q[APSO_I_KMID], regs_q[APSO_I_KLOW]};
            pll_ref_halve_q <= regs_q[APSO_I_PLLB][APSO_B_HALVE];
        end else begin
            pll_int_coef_q <= set_a_integer_coef;
            pll_frac_coef_q <= set_a_fraction_coef;
            pll_ref_halve_q <= set_a_ref_halve;
        end
    end

    // reference tick, every edge or every second edge
    always_ff @(posedge clk) begin
        if (reset) begin
            pll_ref_tick_q <= 1'b0;
        end else begin
            pll_ref_tick_q <= pll_ref_halve_q ? ~pll_ref_tick_q : 1'b1;
        end
    end

    // one output channel of the digital mixer
    function automatic logic [23:0] mix(input logic [1:0] sel,
        input logic [23:0] l, input logic [23:0] r);
        logic [24:0] s;
        s = {l[23], l} + {r[23], r};
        case (sel)
            APSO_MIX_ZERO: mix = 24'h000000;
            APSO_MIX_L: mix = l;
            APSO_MIX_R: mix = r;
            default: begin
                if (s[24] != s[23]) begin
                    mix = s[24] ? 24'h800000 : 24'h7FFFFF;
                end else begin
                    mix = s[23:0];
                end
            end
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (reset) begin
            left_out_q <= 24'h000000;
            right_out_q <= 24'h000000;
        end else if (sample_valid) begin
            left_out_q <= mix(regs_q[APSO_I_MIX][APSO_B_LMIX +: 2],
                left_in, right_in);
            right_out_q <= mix(regs_q[APSO_I_MIX][APSO_B_RMIX +: 2],
                left_in, right_in);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin3_input_enable_q <= 1'b0;
            pin3_in_q <= 1'b0;
            bias_mode_q <= 4'h0;
            core_supply_trim_q <= 2'h0;
        end else begin
            pin3_input_enable_q <= regs_q[APSO_I_PWR][APSO_B_PIN3IE];
            pin3_in_q <= pin3_pad_in & regs_q[APSO_I_PWR][APSO_B_PIN3IE];
            bias_mode_q <= {regs_q[APSO_I_PWR][APSO_B_PGA2B],
                regs_q[APSO_I_PWR][APSO_B_ADCB],
                regs_q[APSO_I_PWR][APSO_B_SPAREB],
                regs_q[APSO_I_PWR][APSO_B_MCBS]};
            core_supply_trim_q <= regs_q[APSO_I_PWR][APSO_B_TRIM +: 2];
        end
    end

    always_comb begin
        case (word_length_setting)
            2'h0: nb_d = APSO_NB_16;
            2'h1: nb_d = APSO_NB_20;
            2'h2: nb_d = APSO_NB_24;
            default: nb_d = APSO_NB_32;
        endcase
        if (regs_q[APSO_I_CTL][APSO_B_BIT8]) begin
            nb_d = APSO_NB_8;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            slot_mode_active_q <= 1'b0;
            dsp_ab_only_q <= 1'b0;
            word_bits_q <= APSO_NB_16;
        end else begin
            slot_mode_active_q <= regs_q[APSO_I_CTL][APSO_B_SLOTEN] &&
                audio_format_field == APSO_FMT_DSP;
            dsp_ab_only_q <= !regs_q[APSO_I_CTL][APSO_B_SLOTEN] &&
                audio_format_field == APSO_FMT_DSP;
            word_bits_q <= nb_d;
        end
    end

    // ten-bit starts; plain dsp puts right after left
    assign start_v[0] = slot_mode_active_q ?
        {regs_q[APSO_I_CTL][APSO_B_LS9], regs_q[APSO_I_LSLOT]} : 10'h000;
    assign start_v[1] = slot_mode_active_q ?
        {regs_q[APSO_I_CTL][APSO_B_RS9], regs_q[APSO_I_RSLOT]} :
        {4'h0, word_bits_q};
    assign word_v[0] = {left_out_q, 8'h00};
    assign word_v[1] = {right_out_q, 8'h00};

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            apso_slot_tx u_tx (
                .clk(clk),
                .reset(reset),
                .frame_start(frame_start),
                .bit_lead(bit_lead),
                .bit_mid(bit_mid),
                .start_cnt(start_v[c]),
                .nbits(word_bits_q),
                .word(word_v[c]),
                .sdo_q(sdo_v[c]),
                .active_q(act_v[c]),
                .lsb_late_q(late_v[c])
            );
        end
    endgenerate

    // early release in late lsb half
    always_comb begin
        if (!regs_q[APSO_I_CTL][APSO_B_OESEL]) begin
            drive_d = !general_output_disable;
        end else if (regs_q[APSO_I_CTL][APSO_B_LOE]) begin
            drive_d = 1'b1;
        end else begin
            drive_d = (|act_v) &&
                !(regs_q[APSO_I_CTL][APSO_B_EARLY] && (|late_v));
        end
    end

    // pad driver, data and weak pull
    always_ff @(posedge clk) begin
        if (reset) begin
            serial_audio_out_pin_o <= 1'b0;
            serial_audio_out_pin_oe_n <= 1'b1;
            output_pull_enable_q <= 1'b0;
            output_pull_select_q <= 1'b0;
        end else begin
            serial_audio_out_pin_o <= act_v[0] ? sdo_v[0] : sdo_v[1];
            serial_audio_out_pin_oe_n <= !drive_d;
            output_pull_enable_q <= regs_q[APSO_I_CTL][APSO_B_PE];
            output_pull_select_q <= regs_q[APSO_I_CTL][APSO_B_PS];
        end
    end

    // checks
    sequence s_late_lsb;
        (|late_v) && regs_q[APSO_I_CTL][APSO_B_EARLY] &&
        regs_q[APSO_I_CTL][APSO_B_OESEL] && !regs_q[APSO_I_CTL][APSO_B_LOE];
    endsequence

    AST_COEF_SEL: assert property (@(posedge clk) disable iff (reset)
        $past(set_b) |-> pll_int_coef_q == $past(regs_q[APSO_I_PLLB][3:0]))
        else $error("set B integer not selected");
    AST_REF_HALF: assert property (@(posedge clk) disable iff (reset)
        pll_ref_halve_q && $past(pll_ref_halve_q) && pll_ref_tick_q
        |=> !pll_ref_tick_q)
        else $error("halved reference ticked twice");
    AST_FRAC: assert property (@(posedge clk) disable iff (reset)
        $past(set_b) |-> pll_frac_coef_q[23:18] ==
        $past(regs_q[APSO_I_KUP][5:0]))
        else $error("fraction upper bits wrong");
    AST_RMIX: assert property (@(posedge clk) disable iff (reset)
        sample_valid && regs_q[APSO_I_MIX][5:4] == APSO_MIX_ZERO
        |=> right_out_q == 24'h000000)
        else $error("right mixer zero code broken");
    AST_LMIX_RST: assert property (@(posedge clk)
        $past(reset) && !reset |-> regs_q[APSO_I_MIX] == APSO_RST[APSO_I_MIX])
        else $error("mixer reset value wrong");
    AST_LMIX: assert property (@(posedge clk) disable iff (reset)
        sample_valid && regs_q[APSO_I_MIX][APSO_B_LMIX +: 2] == APSO_MIX_L
        |=> left_out_q == $past(left_in))
        else $error("left mixer left code broken");
    AST_PIN3: assert property (@(posedge clk) disable iff (reset)
        !$past(regs_q[APSO_I_PWR][APSO_B_PIN3IE]) |-> !pin3_in_q)
        else $error("pin three input passed while disabled");
    AST_PIN3_EN: assert property (@(posedge clk) disable iff (reset)
        pin3_input_enable_q == $past(regs_q[APSO_I_PWR][APSO_B_PIN3IE]))
        else $error("pin three enable not following its bit");
    AST_SLOT: assert property (@(posedge clk) disable iff (reset)
        slot_mode_active_q |-> $past(audio_format_field) == APSO_FMT_DSP)
        else $error("slot mode without dsp format");
    AST_SLOT_OFF: assert property (@(posedge clk) disable iff (reset)
        !$past(regs_q[APSO_I_CTL][APSO_B_SLOTEN]) |-> !slot_mode_active_q)
        else $error("slot mode active while disabled");
    AST_DSP_AB: assert property (@(posedge clk) disable iff (reset)
        dsp_ab_only_q |-> !$past(regs_q[APSO_I_CTL][APSO_B_SLOTEN]))
        else $error("dsp-only flag with slot mode enabled");
    AST_WL8: assert property (@(posedge clk) disable iff (reset)
        regs_q[APSO_I_CTL][APSO_B_BIT8] ##1
        regs_q[APSO_I_CTL][APSO_B_BIT8] |-> word_bits_q == APSO_NB_8)
        else $error("eight-bit word not forced");
    AST_OE_GEN: assert property (@(posedge clk) disable iff (reset)
        !$past(regs_q[APSO_I_CTL][APSO_B_OESEL]) |->
        serial_audio_out_pin_oe_n == $past(general_output_disable))
        else $error("general disable not followed");
    AST_OE_LOC: assert property (@(posedge clk) disable iff (reset)
        $past(regs_q[APSO_I_CTL][APSO_B_OESEL]) &&
        $past(regs_q[APSO_I_CTL][APSO_B_LOE]) |->
        !serial_audio_out_pin_oe_n)
        else $error("local enable did not drive");
    AST_EARLY: assert property (@(posedge clk) disable iff (reset)
        s_late_lsb |=> serial_audio_out_pin_oe_n)
        else $error("pin held in late lsb half");
    AST_PULL: assert property (@(posedge clk) disable iff (reset)
        output_pull_enable_q == $past(regs_q[APSO_I_CTL][APSO_B_PE]) &&
        output_pull_select_q == $past(regs_q[APSO_I_CTL][APSO_B_PS]))
        else $error("pull controls not following their bits");
    AST_RD_RSV: assert property (@(posedge clk) disable iff (reset)
        reg_rd && hit[APSO_I_MIX] |=> (reg_rdata_q & 9'h1CC) == 9'h000)
        else $error("reserved mixer bits read nonzero");
endmodule // apso_regs

// ### hw/apso_pkg.sv
package apso_pkg;
    // register count and field width
    localparam int APSO_NREG = 9;
    localparam int APSO_DW = 9;
    localparam int APSO_AW = 7;
    typedef logic [APSO_DW-1:0] apso_word_t;
    typedef logic [APSO_AW-1:0] apso_addr_t;

    // register indices
    localparam int APSO_I_PLLB = 0;
    localparam int APSO_I_KUP = 1;
    localparam int APSO_I_KMID = 2;
    localparam int APSO_I_KLOW = 3;
    localparam int APSO_I_MIX = 4;
    localparam int APSO_I_PWR = 5;
    localparam int APSO_I_LSLOT = 6;
    localparam int APSO_I_CTL = 7;
    localparam int APSO_I_RSLOT = 8;

    // offsets, writable masks and reset values, by index
    localparam apso_addr_t APSO_ADDR [APSO_NREG] = '{
        7'h4F, 7'h50, 7'h51, 7'h52, 7'h59, 7'h5A, 7'h5B, 7'h5C, 7'h5D};
    localparam apso_word_t APSO_MASK [APSO_NREG] = '{
        9'h03F, 9'h03F, 9'h1FF, 9'h1FF, 9'h033, 9'h1DD, 9'h1FF, 9'h1FF,
        9'h1FF};
    localparam apso_word_t APSO_RST [APSO_NREG] = '{
        9'h000, 9'h000, 9'h000, 9'h000, 9'h021, 9'h000, 9'h000, 9'h000,
        9'h000};

    // field positions
    localparam int APSO_B_SETSEL = 5;
    localparam int APSO_B_HALVE = 4;
    localparam int APSO_B_RMIX = 4;
    localparam int APSO_B_LMIX = 0;
    localparam int APSO_B_PGA2B = 8;
    localparam int APSO_B_ADCB = 7;
    localparam int APSO_B_SPAREB = 6;
    localparam int APSO_B_MCBS = 4;
    localparam int APSO_B_TRIM = 2;
    localparam int APSO_B_PIN3IE = 0;
    localparam int APSO_B_SLOTEN = 8;
    localparam int APSO_B_EARLY = 7;
    localparam int APSO_B_BIT8 = 6;
    localparam int APSO_B_LOE = 5;
    localparam int APSO_B_PE = 4;
    localparam int APSO_B_PS = 3;
    localparam int APSO_B_OESEL = 2;
    localparam int APSO_B_RS9 = 1;
    localparam int APSO_B_LS9 = 0;

    // mixer codes and format code
    localparam logic [1:0] APSO_MIX_ZERO = 2'h0;
    localparam logic [1:0] APSO_MIX_L = 2'h1;
    localparam logic [1:0] APSO_MIX_R = 2'h2;
    localparam logic [1:0] APSO_MIX_SUM = 2'h3;
    localparam logic [1:0] APSO_FMT_DSP = 2'h3;

    // word length codes and bit counts
    localparam logic [5:0] APSO_NB_8 = 6'h08;
    localparam logic [5:0] APSO_NB_16 = 6'h10;
    localparam logic [5:0] APSO_NB_20 = 6'h14;
    localparam logic [5:0] APSO_NB_24 = 6'h18;
    localparam logic [5:0] APSO_NB_32 = 6'h20;

    // serializer states, gray along idle-wait-shift
    typedef enum logic [1:0] {
        APSO_ST_IDLE = 2'b00,
        APSO_ST_WAIT = 2'b01,
        APSO_ST_SHIFT = 2'b11
    } apso_st_e;
endpackage

// ### hw/apso_slot_tx.sv
`timescale 1ns/1ps
module apso_slot_tx (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // frame and bit timing pulses
    input wire logic frame_start,
    input wire logic bit_lead,
    input wire logic bit_mid,
    // word setup
    input wire logic [9:0] start_cnt,
    input wire logic [5:0] nbits,
    input wire logic [31:0] word,
    // serial state
    output logic sdo_q,
    output logic active_q,
    output logic lsb_late_q
);
    import apso_pkg::*;

    apso_st_e st_q;
    logic [9:0] cnt_q;
    logic [5:0] left_q;
    logic [31:0] sh_q;

    // bit-period count from sync, then msb-first shift
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= APSO_ST_IDLE;
            cnt_q <= 10'h000;
            left_q <= 6'h00;
            sh_q <= 32'h0000_0000;
            sdo_q <= 1'b0;
            active_q <= 1'b0;
        end else if (frame_start) begin
            st_q <= APSO_ST_WAIT;
            cnt_q <= 10'h000;
            sh_q <= word;
            active_q <= 1'b0;
        end else if (bit_lead) begin
            case (st_q)
                APSO_ST_WAIT: begin
                    if (cnt_q == start_cnt) begin
                        st_q <= APSO_ST_SHIFT;
                        sdo_q <= sh_q[31];
                        sh_q <= {sh_q[30:0], 1'b0};
                        left_q <= nbits - 6'h01;
                        active_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                APSO_ST_SHIFT: begin
                    if (left_q == 6'h00) begin
                        st_q <= APSO_ST_IDLE;
                        active_q <= 1'b0;
                    end else begin
                        sdo_q <= sh_q[31];
                        sh_q <= {sh_q[30:0], 1'b0};
                        left_q <= left_q - 6'h01;
                    end
                end
                default: st_q <= APSO_ST_IDLE;
            endcase
        end
    end

    // marks the second half of the last bit
    always_ff @(posedge clk) begin
        if (reset || frame_start || bit_lead) begin
            lsb_late_q <= 1'b0;
        end else if (bit_mid && st_q == APSO_ST_SHIFT && left_q == 6'h00) begin
            lsb_late_q <= 1'b1;
        end
    end
endmodule // apso_slot_tx

// ### verif/apso_host_model.sv
`timescale 1ns/1ps
// host side of the parallel register port
module apso_host_model (
    // clock
    input wire logic clk,
    // register port
    output apso_pkg::apso_addr_t reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output apso_pkg::apso_word_t reg_wdata,
    input wire apso_pkg::apso_word_t reg_rdata_q
);
    import apso_pkg::*;

    // idle port at time zero
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 9'h000;
    end

    // one-cycle write strobe, data scrambled once released
    task automatic write_reg(input apso_addr_t a, input apso_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_wdata <= ~d;
    endtask

    // read strobe, answer taken one edge after the strobe edge
    task automatic read_reg(input apso_addr_t a, output apso_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(posedge clk);
        d = reg_rdata_q;
    endtask
endmodule // apso_host_model

// ### verif/apso_regs_tb_top.sv
`timescale 1ns/1ps
module apso_regs_tb_top;
    import apso_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    apso_addr_t reg_addr;
    logic reg_wr, reg_rd, a_halve, gen_dis, sample_valid, pad;
    apso_word_t reg_wdata, reg_rdata_q;
    logic [3:0] a_int, pll_int, bias;
    logic [23:0] a_frac, pll_frac, left_in, right_in, l_out, r_out;
    logic [1:0] wls, fmt, trim;
    logic pll_halve, tick, pie, pin3_in, active, dspab, pin_o, oe_n;
    logic pe, ps, frame_start, bit_lead, bit_mid;
    logic [5:0] wbits;
    logic pin_a [600];
    logic oe_a [600];
    logic late_a [600];
    int bad_count = 0;
    int num_checks = 0;
    localparam logic [5:0] NB [4] = '{6'h10, 6'h14, 6'h18, 6'h20};

    apso_host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

    apso_regs uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .set_a_integer_coef(a_int),
        .set_a_fraction_coef(a_frac), .set_a_ref_halve(a_halve),
        .general_output_disable(gen_dis), .word_length_setting(wls),
        .audio_format_field(fmt), .pll_int_coef_q(pll_int),
        .pll_frac_coef_q(pll_frac), .pll_ref_halve_q(pll_halve),
        .pll_ref_tick_q(tick), .sample_valid(sample_valid),
        .left_in(left_in), .right_in(right_in), .left_out_q(l_out),
        .right_out_q(r_out), .bias_mode_q(bias),
        .core_supply_trim_q(trim), .pin3_pad_in(pad),
        .pin3_input_enable_q(pie), .pin3_in_q(pin3_in),
        .frame_start(frame_start), .bit_lead(bit_lead), .bit_mid(bit_mid),
        .slot_mode_active_q(active), .dsp_ab_only_q(dspab),
        .word_bits_q(wbits), .serial_audio_out_pin_o(pin_o),
        .serial_audio_out_pin_oe_n(oe_n), .output_pull_enable_q(pe),
        .output_pull_select_q(ps));

    // clock, 40 ns period
    always #20 clk = ~clk;

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input apso_addr_t a, input apso_word_t exp);
        apso_word_t v;
        h.read_reg(a, v);
        chk(v, exp);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // one frame of eight-cycle bit periods, pin data sampled mid, output enable sampled mid and late
    task automatic run_frame(input int n);
        @(posedge clk);
        frame_start <= 1'h1;
        @(posedge clk);
        frame_start <= 1'h0;
        for (int p = 0; p < n; p++) begin
            bit_lead <= 1'h1;
            @(posedge clk);
            bit_lead <= 1'h0;
            repeat (3) @(posedge clk);
            bit_mid <= 1'h1;
            @(posedge clk);
            bit_mid <= 1'h0;
            pin_a[p] = pin_o;
            oe_a[p] = oe_n;
            repeat (3) @(posedge clk);
            late_a[p] = oe_n;
        end
    endtask

    // left word from period 512, right from 522, eight bits each
    task automatic chk_frame(input logic early);
        int li, ri;
        for (int p = 508; p < 534; p++) begin
            li = p - 512;
            ri = p - 522;
            if (li >= 0 && li < 8) begin
                chk(oe_a[p], 1'h0);
                chk(pin_a[p], left_in[23 - li]);
            end else if (ri >= 0 && ri < 8) begin
                chk(oe_a[p], 1'h0);
                chk(pin_a[p], right_in[23 - ri]);
            end else begin
                chk(oe_a[p], 1'h1);
            end
        end
        chk(late_a[518], 1'h0);
        chk(late_a[519], early);
        chk(late_a[529], early);
    endtask

    // hang guard
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    // main sequence
    initial begin
        logic t;
        logic [23:0] mx [4];
        a_int = 4'h9;
        a_frac = 24'h5A5A5A;
        a_halve = 1'h0;
        gen_dis = 1'h1;
        wls = 2'h0;
        fmt = 2'h0;
        pad = 1'h1;
        sample_valid = 1'h0;
        left_in = 24'h000123;
        right_in = 24'h000456;
        frame_start = 1'h0;
        bit_lead = 1'h0;
        bit_mid = 1'h0;
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        for (int i = 0; i < APSO_NREG; i++) begin
            rd_chk(APSO_ADDR[i], APSO_RST[i]);
        end
        chk(wbits, APSO_NB_16);
        chk(oe_n, 1'h1);
        for (int i = 0; i < APSO_NREG; i++) begin
            h.write_reg(APSO_ADDR[i], 9'h1FF);
            rd_chk(APSO_ADDR[i], APSO_MASK[i]);
        end
        h.write_reg(7'h53, 9'h1FF);
        rd_chk(7'h53, 9'h000);
        chk({pll_int, pll_frac, pll_halve}, {4'hF, 24'hFFFFFF, 1'h1});
        t = tick;
        @(posedge clk);
        chk(tick, !t);
        chk(wbits, APSO_NB_8);
        chk({pe, ps, oe_n}, 3'h6);
        chk({bias, trim, pie, pin3_in}, 8'hFF);
        pad <= 1'h0;
        settle();
        chk(pin3_in, 1'h0);
        pad <= 1'h1;
        chk(active, 1'h0);
        // set A selected, then set B with distinct fields
        h.write_reg(7'h4F, 9'h00A);
        settle();
        chk({pll_int, pll_frac}, {a_int, a_frac});
        chk({pll_halve, tick}, 2'h1);
        h.write_reg(7'h50, 9'h02A);
        h.write_reg(7'h51, 9'h155);
        h.write_reg(7'h52, 9'h0F0);
        h.write_reg(7'h4F, 9'h02A);
        settle();
        chk({pll_int, pll_frac}, {4'hA, 6'h2A, 9'h155, 9'h0F0});
        chk({pll_halve, tick}, 2'h1);
        @(posedge clk);
        chk(tick, 1'h1);
        // every mixer code on both channels
        mx = '{24'h000000, 24'h000123, 24'h000456, 24'h000579};
        for (int c = 0; c < 4; c++) begin
            h.write_reg(7'h59, {3'h0, c[1:0], 2'h0, c[1:0]});
            @(posedge clk);
            sample_valid <= 1'h1;
            @(posedge clk);
            sample_valid <= 1'h0;
            settle();
            chk({l_out, r_out}, {mx[c], mx[c]});
        end
        // slot mode against every format, enable on then off
        for (int e = 1; e >= 0; e--) begin
            h.write_reg(7'h5C, e ? 9'h100 : 9'h000);
            for (int f = 0; f < 4; f++) begin
                fmt <= f[1:0];
                settle();
                chk(active, e == 1 && f == 3);
                chk(dspab, e == 0 && f == 3);
            end
        end
        for (int w = 0; w < 4; w++) begin
            wls <= w[1:0];
            settle();
            chk(wbits, NB[w]);
        end
        chk({oe_n, pe}, 2'h2);
        gen_dis <= 1'h0;
        settle();
        chk(oe_n, 1'h0);
        gen_dis <= 1'h1;
        h.write_reg(7'h5C, 9'h010);
        settle();
        chk({pe, ps, oe_n}, 3'h5);
        h.write_reg(7'h5A, 9'h000);
        settle();
        chk({pie, pin3_in}, 2'h0);
        // serial frames, slot starts 0x200 and 0x20A
        h.write_reg(7'h59, 9'h021);
        left_in <= 24'hA51234;
        right_in <= 24'h3C5678;
        sample_valid <= 1'h1;
        @(posedge clk);
        sample_valid <= 1'h0;
        fmt <= 2'h3;
        wls <= 2'h0;
        h.write_reg(7'h5B, 9'h000);
        h.write_reg(7'h5D, 9'h00A);
        h.write_reg(7'h5C, 9'h147);
        run_frame(534);
        chk_frame(1'h0);
        h.write_reg(7'h5C, 9'h1C7);
        run_frame(534);
        chk_frame(1'h1);
        stop_test();
    end
endmodule // apso_regs_tb_top
